// >>> rtl/tem_pkg.sv
/*
 * Shared constants and carrier types for the timer external match block.
 * Assumes a 32-bit AXI4-Lite register bus and a 4-channel match timer.
 */
package tem_pkg;
    localparam int unsigned NUM_CH = 4;
    // Byte address of the external match control register.
    localparam logic [31:0] EXT_MATCH_CTRL_ADDR = 32'h4000c03c;
    // Low address bits used for decode inside the 4 KiB peripheral page.
    localparam logic [11:0] EXT_MATCH_CTRL_OFS = 12'h03c;
    // Field positions.
    localparam int unsigned STATE_LSB = 0;
    localparam int unsigned ACTION_LSB = 4;
    localparam int unsigned ACTION_W = 2;
    localparam int unsigned USED_BITS = 12;
    // Reset values.
    localparam logic [3:0] STATE_RESET = 4'h0;
    localparam logic [7:0] ACTION_RESET = 8'h00;
    // Match action codes.
    typedef enum logic [1:0] {
        TEM_ACT_NONE = 2'h0,
        TEM_ACT_CLEAR = 2'h1,
        TEM_ACT_SET = 2'h2,
        TEM_ACT_TOGGLE = 2'h3
    } tem_action_t;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Per-channel match and PWM strobes and the shared timer reset from the counter core.
    typedef struct packed {
        logic [3:0] match_hit;   // Counter equals match value n.
        logic [3:0] pwm_enable;  // PWM mode per channel.
        logic timer_reset;       // Counter wrapped or reset to zero.
    } tem_events_t;
    // Bus state machine, one-hot.
    typedef enum logic [2:0] {
        TEM_BUS_IDLE = 3'b001,
        TEM_BUS_WRESP = 3'b010,
        TEM_BUS_RDATA = 3'b100
    } tem_bus_state_t;
endpackage : tem_pkg

// >>> rtl/tem_match_outputs.sv
/*
 * External match output logic of a 16-bit counter/timer, with its control
 * register on AXI4-Lite. Assumes the counter core supplies one-cycle match
 * strobes, a timer reset strobe and the PWM enables on aclk; pin selection
 * comes from the pin function multiplexer, synchronous to aclk.
 */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps

module tem_match_outputs #(
    parameter bit FIRST_INSTANCE = 1'b1  // Instance lacks a channel 2 pin.
) (
    input wire logic aclk,                       // Peripheral clock.
    input wire logic aresetn,                    // Synchronous reset, low.
    input wire logic [31:0] s_axi_awaddr,        // Write address.
    input wire logic s_axi_awvalid,              // Write address valid.
    output logic s_axi_awready,                  // Write address ready.
    input wire logic [31:0] s_axi_wdata,         // Write data.
    input wire logic [3:0] s_axi_wstrb,          // Write byte strobes.
    input wire logic s_axi_wvalid,               // Write data valid.
    output logic s_axi_wready,                   // Write data ready.
    output logic [1:0] s_axi_bresp,              // Write response.
    output logic s_axi_bvalid,                   // Write response valid.
    input wire logic s_axi_bready,               // Write response ready.
    input wire logic [31:0] s_axi_araddr,        // Read address.
    input wire logic s_axi_arvalid,              // Read address valid.
    output logic s_axi_arready,                  // Read address ready.
    output logic [31:0] s_axi_rdata,             // Read data.
    output logic [1:0] s_axi_rresp,              // Read response.
    output logic s_axi_rvalid,                   // Read data valid.
    input wire logic s_axi_rready,               // Read data ready.
    input wire tem_pkg::tem_events_t events,     // Strobes from timer core.
    input wire logic [3:0] pin_function_select,  // Match function on pin.
    output logic [3:0] match_output_pin,         // Pin output levels.
    output logic [3:0] match_output_pin_oe,      // Pin output enables.
    output logic [3:0] match_level               // Channel levels, internal.
);
    logic [3:0] out_state;
    logic [3:0] next_out_state;
    logic [7:0] action;
    logic [7:0] next_action;
    logic [3:0] next_pin;
    logic [3:0] next_pin_oe;
    tem_pkg::tem_bus_state_t bus_state;
    tem_pkg::tem_bus_state_t next_bus_state;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [31:0] awaddr_q;
    logic [31:0] next_awaddr_q;
    logic [31:0] wdata_q;
    logic [31:0] next_wdata_q;
    logic [3:0] wstrb_q;
    logic [3:0] next_wstrb_q;
    logic [1:0] bresp_q;
    logic [1:0] next_bresp_q;
    logic [31:0] rdata_q;
    logic [31:0] next_rdata_q;
    logic [1:0] rresp_q;
    logic [1:0] next_rresp_q;
    logic do_write;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] reg_view;
    logic [3:0] ch_next;
    logic [31:0] wdata_now;
    logic [3:0] wstrb_now;

    // Whole register as software sees it; reserved bits read as zero.
    assign reg_view = {20'h00000, action, out_state};
    // The write decode must use the live address when it arrives in the
    // same cycle as the write is taken, so it goes through the selector.
    assign wr_hit = wr_addr_ok();
    assign rd_hit = s_axi_araddr[11:2] == tem_pkg::EXT_MATCH_CTRL_OFS[11:2];
    assign do_write = (bus_state == tem_pkg::TEM_BUS_IDLE)
        && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

    // Per-channel next level. PWM wins over the action field because the
    // counter core owns the waveform in that mode.
    //
    // Each channel is a small mux in front of one flip-flop of out_state.
    // The match strobe is a single-cycle pulse from the counter core, so the
    // action is applied exactly once per match. A strobe that stays high
    // for several cycles would reapply the action on every one of them; the
    // counter core is expected never to do that.
    //
    // In PWM mode the match strobe raises the level and the timer reset
    // strobe lowers it. When both come in one cycle the match wins, which
    // keeps a match value of zero from producing a stuck low output.
    //
    // Codes outside the enum cannot occur in two bits; the default branch
    // only keeps the case complete for the linter and for synthesis.
    for (genvar ch = 0; ch < 4; ch++) begin : g_ch
        always_comb begin
            ch_next[ch] = out_state[ch];
            if (events.pwm_enable[ch]) begin
                if (events.match_hit[ch]) begin
                    ch_next[ch] = 1'b1;
                end else if (events.timer_reset) begin
                    ch_next[ch] = 1'b0;
                end
            end else if (events.match_hit[ch]) begin
                case (tem_pkg::tem_action_t'(action[2*ch +: 2]))
                    tem_pkg::TEM_ACT_NONE: ch_next[ch] = out_state[ch];
                    tem_pkg::TEM_ACT_CLEAR: ch_next[ch] = 1'b0;
                    tem_pkg::TEM_ACT_SET: ch_next[ch] = 1'b1;
                    tem_pkg::TEM_ACT_TOGGLE: ch_next[ch] = ~out_state[ch];
                    default: ch_next[ch] = out_state[ch];
                endcase
            end
        end
    end

    // Register and level update. A same-cycle match beats a software write
    // to the state bits so that no timer event is lost.
    always_comb begin
        next_out_state = ch_next;
        next_action = action;
        if (do_write && wr_hit) begin
            if (wstrb_now[0]) begin
                // Bits 31:12 are ignored; software should keep them zero.
                next_action[3:0] = wdata_now[7:4];
                for (int i = 0; i < 4; i++) begin
                    if (!events.match_hit[i] && !events.pwm_enable[i]) begin
                        next_out_state[i] = wdata_now[i];
                    end
                end
            end
            if (wstrb_now[1]) begin
                next_action[7:4] = wdata_now[11:8];
            end
        end
    end

    // Pin drive follows the next level so pins and readback line up.
    always_comb begin
        next_pin = next_out_state;
        next_pin_oe = pin_function_select;
        if (FIRST_INSTANCE) begin
            next_pin[2] = 1'b0;
            next_pin_oe[2] = 1'b0;
        end
    end

    // Bus handshake: address and data may arrive in either order.
    //
    // Write address and write data are each held in a small capture stage
    // when they arrive alone. The write is taken in the cycle in which the
    // second of the two is seen, so a master that offers both together is
    // answered with bvalid right after the taking edge, in the next cycle.
    //
    // A read is taken only when no write is pending or arriving. This
    // gives writes priority and keeps the read data consistent with any
    // write that the master has already offered.
    //
    // Only one transfer is under way at a time. While a response waits
    // for bready or rready, all three ready outputs stay low, so a master
    // that offers the next request early simply waits.
    //
    // An address outside this register is answered with a slave error and
    // has no effect; a refused read returns zero data.
    //
    // The ready outputs are decoded from state, and arready also from the write
    // valid inputs, as the channel rules allow. They cannot come from flip-flops without
    // adding a cycle of latency to every transfer, which was not wanted.
    always_comb begin
        next_bus_state = bus_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bresp_q = bresp_q;
        next_rdata_q = rdata_q;
        next_rresp_q = rresp_q;
        case (bus_state)
            tem_pkg::TEM_BUS_IDLE: begin
                if (!aw_held && s_axi_awvalid) begin
                    next_aw_held = 1'b1;
                    next_awaddr_q = s_axi_awaddr;
                end
                if (!w_held && s_axi_wvalid) begin
                    next_w_held = 1'b1;
                    next_wdata_q = s_axi_wdata;
                    next_wstrb_q = s_axi_wstrb;
                end
                if (do_write) begin
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_bresp_q = wr_addr_ok() ? tem_pkg::RESP_OKAY
                                                : tem_pkg::RESP_SLVERR;
                    next_bus_state = tem_pkg::TEM_BUS_WRESP;
                end else if (s_axi_arvalid && !aw_held && !w_held
                             && !s_axi_awvalid && !s_axi_wvalid) begin
                    next_rdata_q = rd_hit ? reg_view : 32'h00000000;
                    next_rresp_q = rd_hit ? tem_pkg::RESP_OKAY
                                          : tem_pkg::RESP_SLVERR;
                    next_bus_state = tem_pkg::TEM_BUS_RDATA;
                end
            end
            tem_pkg::TEM_BUS_WRESP: begin
                if (s_axi_bready) begin
                    next_bus_state = tem_pkg::TEM_BUS_IDLE;
                end
            end
            tem_pkg::TEM_BUS_RDATA: begin
                if (s_axi_rready) begin
                    next_bus_state = tem_pkg::TEM_BUS_IDLE;
                end
            end
            default: next_bus_state = tem_pkg::TEM_BUS_IDLE;
        endcase
    end

    // Effective write payload: the held copy or the live channel.
    function automatic logic [31:0] wdata_eff();
        return w_held ? wdata_q : s_axi_wdata;
    endfunction : wdata_eff

    function automatic logic [3:0] s_axi_wstrb_eff();
        return w_held ? wstrb_q : s_axi_wstrb;
    endfunction : s_axi_wstrb_eff

    function automatic logic wr_addr_ok();
        logic [31:0] a;
        a = aw_held ? awaddr_q : s_axi_awaddr;
        return a[11:2] == tem_pkg::EXT_MATCH_CTRL_OFS[11:2];
    endfunction : wr_addr_ok

    // All state registers; every output below except s_axi_arready comes from these alone.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_state <= tem_pkg::STATE_RESET;
            action <= tem_pkg::ACTION_RESET;
            match_output_pin <= 4'h0;
            match_output_pin_oe <= 4'h0;
            match_level <= 4'h0;
            bus_state <= tem_pkg::TEM_BUS_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= 2'h0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end else begin
            out_state <= next_out_state;
            action <= next_action;
            match_output_pin <= next_pin;
            match_output_pin_oe <= next_pin_oe;
            match_level <= next_out_state;
            bus_state <= next_bus_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            bresp_q <= next_bresp_q;
            rdata_q <= next_rdata_q;
            rresp_q <= next_rresp_q;
        end
    end

    // Valid and response outputs are decoded from registered state only.
    assign s_axi_bvalid = bus_state == tem_pkg::TEM_BUS_WRESP;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = bus_state == tem_pkg::TEM_BUS_RDATA;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Each capture stage accepts while idle and empty. A read is accepted
    // only when nothing of a write is held or offered, matching the take
    // condition of the bus state machine above.
    assign s_axi_awready = (bus_state == tem_pkg::TEM_BUS_IDLE) && !aw_held;
    assign s_axi_wready = (bus_state == tem_pkg::TEM_BUS_IDLE) && !w_held;
    assign s_axi_arready = (bus_state == tem_pkg::TEM_BUS_IDLE)
        && !aw_held && !w_held && !s_axi_awvalid && !s_axi_wvalid;

    // Effective write payload as plain signals, so single bits can be
    // selected from it in the register update.
    assign wdata_now = wdata_eff();
    assign wstrb_now = s_axi_wstrb_eff();

    // Limitations worth knowing: the byte strobes only matter for lanes 0
    // and 1, since lanes 2 and 3 hold reserved bits only. A partial write
    // to lane 1 alone changes the upper two action fields and leaves the
    // state bits and the lower fields untouched.
    //
    // The pins follow the state bits with the same one-cycle register
    // delay as the readback, so software never sees a level that the pin
    // has not yet shown. On the first timer instance channel 2 keeps its
    // level internally but its pin enable stays low at all times.
endmodule : tem_match_outputs

// >>> sim/tem_pad_model.sv
/* Pad side of the match outputs, behind the pin function multiplexer.
   Assumes pin levels and enables come from the block on aclk. */
`timescale 1ns/1ps
module tem_pad_model (
    input wire logic aclk,  // Clock.
    input wire logic [3:0] drive,  // Driven levels.
    input wire logic [3:0] oe,  // Enables, high while driven.
    output logic [3:0] pad  // Pad levels.
);
    logic [3:0] last;
    // An undriven pad keeps flipping, so a stale level never passes.
    always @(posedge aclk) last <= pad;
    always_comb pad = (oe & drive) | (~oe & ~last);
endmodule : tem_pad_model

// >>> sim/tem_match_outputs_asserts.sv
/* Checker for the match output block.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ps
module tem_match_outputs_asserts #(
    parameter bit FIRST_INSTANCE = 1'h1  // Same as the block.
) (
    input wire logic aclk,  // Clock.
    input wire logic aresetn,  // Reset, low.
    input wire tem_pkg::tem_events_t events,  // Timer strobes.
    input wire logic [3:0] pin_function_select,  // Pin select.
    input wire logic [3:0] match_output_pin,  // Pin levels.
    input wire logic [3:0] match_output_pin_oe,  // Pin enables.
    input wire logic [3:0] match_level,  // Channel levels.
    input wire logic s_axi_awvalid,  // Write address valid.
    input wire logic s_axi_wvalid,  // Write data valid.
    input wire logic s_axi_bvalid,  // Write response valid.
    input wire logic s_axi_bready  // Write response ready.
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Channels that a PWM event forces high or low.
    logic [3:0] pwm_hi;
    logic [3:0] pwm_lo;
    assign pwm_hi = events.pwm_enable & events.match_hit;
    assign pwm_lo = events.pwm_enable & ~events.match_hit
        & {4{events.timer_reset}};
    a_reset_clears:
    assert property ($rose(aresetn) |-> match_level == 4'h0)
        else $error("Levels not cleared by reset.");
    a_pin_level:
    assert property ((match_output_pin & match_output_pin_oe)
        == (match_level & match_output_pin_oe)) else $error("Pin level.");
    a_ch2_no_pin:
    assert property (FIRST_INSTANCE |-> !match_output_pin_oe[2])
        else $error("Channel 2 drives a pin.");
    a_oe_select:
    assert property ($stable(pin_function_select) |=> match_output_pin_oe
        == ($past(pin_function_select) & (FIRST_INSTANCE ? 4'hb : 4'hf)))
        else $error("Pin enable does not follow select.");
    a_pwm_high:
    assert property (pwm_hi != 4'h0 |=>
        (match_level & $past(pwm_hi)) == $past(pwm_hi))
        else $error("PWM match did not set output.");
    a_pwm_low:
    assert property (pwm_lo != 4'h0 |=> (match_level & $past(pwm_lo)) == 4'h0)
        else $error("PWM timer reset did not clear output.");
    a_level_hold:
    assert property (events.match_hit == 4'h0 && !events.timer_reset
        && !s_axi_awvalid && !s_axi_wvalid |=> $stable(match_level))
        else $error("Level changed without cause.");
    a_bresp_once:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response repeated.");
endmodule : tem_match_outputs_asserts

// >>> sim/tb.sv
/* Testbench for the match output block: register, match, PWM and pins.
   Assumes the block, its package, the checker and the pad model. */
`timescale 1ns/1ps
module tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] sel = '0, pin, oe, lvl, pad;
    tem_pkg::tem_events_t ev = '0;
    logic [33:0] exp_q[$];
    int num_errors = 0, n_compared = 0, seed = 59143, cycles = 0;
    localparam logic [31:0] A = tem_pkg::EXT_MATCH_CTRL_ADDR;
    localparam logic [1:0] OK = tem_pkg::RESP_OKAY;
    tem_match_outputs #(.FIRST_INSTANCE(1'h1)) i_dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .events(ev), .pin_function_select(sel),
        .match_output_pin(pin), .match_output_pin_oe(oe), .match_level(lvl));
    tem_pad_model i_pad (.aclk(aclk), .drive(pin), .oe(oe), .pad(pad));
    // Clock and a cycle ceiling well above the run's length.
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Answers are compared with the oldest note; one transfer at a time.
    always @(negedge aclk) begin
        if (rvalid === 1'h1 && rready) check({rresp, rdata}, exp_q.pop_front());
        if (bvalid === 1'h1 && bready) check({bresp, 32'h0}, exp_q.pop_front());
    end
    // Write master: each channel is released at the edge that takes it.
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid === 1'h1;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'h0;
            if (w_hs) wvalid <= 1'h0;
        end while (!b_hs);
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        logic ar_hs, r_hs;
        exp_q.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid === 1'h1;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'h0;
        end while (!r_hs);
        rready <= 1'h0;
    endtask : rd
    task automatic pulse(input logic [3:0] h, input logic t);
        @(posedge aclk);
        ev.match_hit <= h;
        ev.timer_reset <= t;
        @(posedge aclk);
        ev.match_hit <= 4'h0;
        ev.timer_reset <= 1'h0;
    endtask : pulse
    function automatic logic next_bit(input logic b, input logic [1:0] c);
        return (c == 2'h0) ? b : (c == 2'h3) ? ~b : c[1];
    endfunction : next_bit
    // Main sequence: refusals, every code on every channel, then PWM.
    initial begin
        logic [3:0] s, e;
        logic [7:0] act;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        wr(A + 32'h4, 32'h0000_0fff, tem_pkg::RESP_SLVERR);
        rd(A + 32'h4, {tem_pkg::RESP_SLVERR, 32'h0});
        rd(A, {OK, 32'h0});
        for (int n = 0; n < 4; n++) begin
            for (int c = 0; c < 4; c++) begin
                s = 4'($random(seed));
                act = 8'h00;
                act[2 * n +: 2] = 2'(c);
                e = s;
                e[n] = next_bit(s[n], 2'(c));
                sel <= 4'($random(seed));
                wr(A, {20'h0, act, s}, OK);
                pulse(4'h1 << n, 1'h0);
                rd(A, {OK, 20'h0, act, e});
                @(negedge aclk);
                check({30'h0, oe}, {30'h0, sel & 4'hb});
                check({30'h0, pad & sel & 4'hb}, {30'h0, e & sel & 4'hb});
                check({30'h0, lvl}, {30'h0, e});
            end
        end
        ev.pwm_enable <= 4'h2;
        wr(A, {20'h0, 8'h0c, 4'h2}, OK);
        pulse(4'h2, 1'h0);
        rd(A, {OK, 20'h0, 8'h0c, 4'h2});
        pulse(4'h0, 1'h1);
        rd(A, {OK, 20'h0, 8'h0c, 4'h0});
        conclude();
    end
endmodule : tb
bind tem_match_outputs tem_match_outputs_asserts #(
    .FIRST_INSTANCE(FIRST_INSTANCE)) i_chk (.aclk(aclk), .aresetn(aresetn),
    .events(events), .pin_function_select(pin_function_select),
    .match_output_pin(match_output_pin), .match_level(match_level),
    .match_output_pin_oe(match_output_pin_oe), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));
